/* rtl/hwc_halt_wakeup_control.sv */
// Overview of operation
// - opcode 8E starts halt entry
// - timer enables select active-halt
// - reset exit waits startup then vector
// - interrupt exit from active-halt immediate
// - active-halt entry clears interrupt mask
// - active-halt keeps oscillator, timer and CPU clock only
// - active-halt suppresses watchdog halt reset
// - active-halt exits on allowed interrupts, reset
// - auto-wake enable selects auto-wake halt
// - RC through fixed divider and prescaler
// - delay end sets flag, startup, service
// - status read clears flag, writes ignored
// - measure bit routes RC to capture
// - auto-wake entry forces mask to zero
// - auto-wake halt stops main oscillator
// - watchdog option may reset on halt
// - auto-wake exits on reset or interrupts
// - status register layout, reset 00h
// - multiplier adds extra startup delay
// - halt lasts 64 times prescale periods
// - plain halt when both others disabled
module hwc_halt_wakeup_control (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // CPU core
   input wire logic opcode_fetch,
   input wire logic [7:0] opcode,
   input wire logic wake_irq_pending,
   input wire logic realtime_base_interrupt,
   input wire logic wake_reset_req,
   input wire logic watchdog_active,
   output logic cpu_stall,
   output logic clear_int_mask,
   output logic fetch_reset_vector,
   output logic service_irq,
   output logic wake_irq,
   output logic watchdog_reset,
   // Clock gating
   output logic main_osc_enable,
   output logic periph_clk_enable,
   output logic timer_clk_enable,
   output logic cpu_clk_out_enable,
   // Wake-up RC oscillator
   input wire logic wake_rc_clk_pin,
   output logic wake_rc_enable,
   output logic capture_route_rc
);

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   logic auto_wake_enable_ff;
   logic wake_osc_measure_enable_ff;
   logic wake_elapsed_flag_ff;
   logic [7:0] wake_prescaler_ff;
   logic [3:0] timer_ctrl_ff;
   logic [2:0] options_ff;
   hwc_pkg::hwc_state_type state_ff, nxt_state;
   logic exit_by_reset_ff, nxt_exit_by_reset;
   logic [12:0] cnt_ff, nxt_cnt;
   logic rc_s1_ff, rc_s2_ff, rc_s3_ff;
   logic dph_ff, dph_wr_ff;
   logic [11:0] dph_addr_ff;
   logic [31:0] hrdata_ff;
   logic cpu_stall_ff, clear_mask_ff, fetch_rv_ff, service_ff;
   logic wdg_rst_ff, osc_ff, periph_ff, timer_ff, cpuclk_ff;
   logic rc_en_ff, route_ff;
   logic timer_done;

   // ------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------
   // Address phase accepted when selected and bus ready
   wire addr_ok = hsel && hready && htrans[1];
   wire wr_go = dph_ff && dph_wr_ff;
   wire wr_ctrl = wr_go && (dph_addr_ff == hwc_pkg::ADDR_CTRL_STATUS);
   wire wr_pre = wr_go && (dph_addr_ff == hwc_pkg::ADDR_PRESCALER);
   wire wr_tmr = wr_go && (dph_addr_ff == hwc_pkg::ADDR_TIMER_CTRL);
   wire wr_opt = wr_go && (dph_addr_ff == hwc_pkg::ADDR_OPTIONS);
   // Next values; a read right behind a write must see the new data
   wire nxt_auto_wake = wr_ctrl ? hwdata[hwc_pkg::BIT_AUTO_WAKE_ENABLE] :
      auto_wake_enable_ff;
   wire nxt_measure = wr_ctrl ? hwdata[hwc_pkg::BIT_MEASURE_ENABLE] :
      wake_osc_measure_enable_ff;
   wire [7:0] nxt_prescaler = wr_pre ? hwdata[7:0] : wake_prescaler_ff;
   wire [3:0] nxt_timer_ctrl = wr_tmr ? hwdata[3:0] : timer_ctrl_ff;
   wire [2:0] nxt_options = wr_opt ? hwdata[2:0] : options_ff;
   // Read taken at address phase so data comes from a register
   wire rd_go = addr_ok && !hwrite;
   wire rd_ctrl = rd_go && (haddr == hwc_pkg::ADDR_CTRL_STATUS);
   wire [7:0] ctrl_view = {5'h00, wake_elapsed_flag_ff,
      nxt_measure, nxt_auto_wake};
   wire [31:0] rd_mux =
      (haddr == hwc_pkg::ADDR_CTRL_STATUS) ? {24'h000000, ctrl_view} :
      (haddr == hwc_pkg::ADDR_PRESCALER) ? {24'h000000, nxt_prescaler} :
      (haddr == hwc_pkg::ADDR_TIMER_CTRL) ? {28'h0000000, nxt_timer_ctrl} :
      (haddr == hwc_pkg::ADDR_OPTIONS) ? {29'h00000000, nxt_options} :
      (haddr == hwc_pkg::ADDR_STATE) ? {29'h00000000, state_ff} :
      32'h00000000;

   // Data phase tracking
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_ff <= 1'b0;
         dph_wr_ff <= 1'b0;
         dph_addr_ff <= 12'h000;
      end else if (hready) begin
         dph_ff <= addr_ok;
         dph_wr_ff <= addr_ok && hwrite;
         dph_addr_ff <= haddr;
      end
   end

   // Read data register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= 32'h00000000;
      end else if (rd_go) begin
         hrdata_ff <= rd_mux;
      end
   end

   // ------------------------------------------------------------------
   // Halt decisions
   // ------------------------------------------------------------------
   // halt opcode detect
   wire halt_fetch = opcode_fetch && (opcode == hwc_pkg::OPCODE_HALT)
      && (state_ff == hwc_pkg::ST_RUN);
   wire active_sel = timer_ctrl_ff[hwc_pkg::BIT_TB_IRQ_ENABLE] ||
      (timer_ctrl_ff[hwc_pkg::BIT_OVF_IRQ_ENABLE] &&
       !timer_ctrl_ff[hwc_pkg::BIT_CLK_SEL_HIGH] &&
       timer_ctrl_ff[hwc_pkg::BIT_CLK_SEL_LOW]);
   // no watchdog reset while active-halt enabled
   // option decides watchdog reset in halt
   wire wdg_trip = watchdog_active && !active_sel &&
      !options_ff[hwc_pkg::BIT_WDG_HALT_OPT];
   wire [12:0] startup_len = options_ff[hwc_pkg::BIT_LONG_STARTUP] ?
      hwc_pkg::STARTUP_LONG : hwc_pkg::STARTUP_SHORT;
   wire rc_tick = rc_s2_ff && !rc_s3_ff;

   // RC ticks through divider and prescaler
   hwc_wake_timer u_wake_timer (
      .hclk(hclk),
      .hresetn(hresetn),
      .run(state_ff == hwc_pkg::ST_AUTO_WAKE),
      .rc_tick(rc_tick),
      .prescale(wake_prescaler_ff),
      .done(timer_done)
   );

   // Next state logic
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_exit_by_reset = exit_by_reset_ff;
      unique case (state_ff)
         hwc_pkg::ST_RUN: begin
            if (halt_fetch && !wdg_trip) begin
               if (auto_wake_enable_ff) begin
                  nxt_state = hwc_pkg::ST_AUTO_WAKE;
               end else if (active_sel) begin
                  nxt_state = hwc_pkg::ST_ACTIVE_HALT;
               end else begin
                  nxt_state = hwc_pkg::ST_HALT;
               end
            end
         end
         hwc_pkg::ST_ACTIVE_HALT: begin
            if (wake_reset_req) begin
               nxt_state = hwc_pkg::ST_STARTUP;
               nxt_exit_by_reset = 1'b1;
               nxt_cnt = startup_len;
            end else if (realtime_base_interrupt || wake_irq_pending) begin
               nxt_state = hwc_pkg::ST_RUN;
               nxt_exit_by_reset = 1'b0;
            end
         end
         hwc_pkg::ST_HALT, hwc_pkg::ST_AUTO_WAKE: begin
            if (wake_reset_req || wake_irq_pending || timer_done) begin
               nxt_state = hwc_pkg::ST_STARTUP;
               nxt_exit_by_reset = wake_reset_req;
               nxt_cnt = startup_len;
            end
         end
         hwc_pkg::ST_STARTUP: begin
            if (cnt_ff == 13'h0001) begin
               if (options_ff[hwc_pkg::BIT_MULT_ENABLE]) begin
                  nxt_state = hwc_pkg::ST_MULT;
                  nxt_cnt = hwc_pkg::MULT_STARTUP;
               end else begin
                  nxt_state = hwc_pkg::ST_RUN;
               end
            end else begin
               nxt_cnt = cnt_ff - 13'h0001;
            end
         end
         hwc_pkg::ST_MULT: begin
            if (cnt_ff == 13'h0001) begin
               nxt_state = hwc_pkg::ST_RUN;
            end else begin
               nxt_cnt = cnt_ff - 13'h0001;
            end
         end
         default: begin
            nxt_state = hwc_pkg::ST_RUN;
         end
      endcase
   end

   // Power state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= hwc_pkg::ST_RUN;
         cnt_ff <= 13'h0000;
         exit_by_reset_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         exit_by_reset_ff <= nxt_exit_by_reset;
      end
   end

   // RC pin synchroniser; edge detect compares stages two and three
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rc_s1_ff <= 1'b0;
         rc_s2_ff <= 1'b0;
         rc_s3_ff <= 1'b0;
      end else begin
         rc_s1_ff <= wake_rc_clk_pin;
         rc_s2_ff <= rc_s1_ff;
         rc_s3_ff <= rc_s2_ff;
      end
   end

   // ------------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------------
   // Configuration writes, low byte lane only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         auto_wake_enable_ff <= hwc_pkg::RST_CTRL_STATUS[0];
         wake_osc_measure_enable_ff <= hwc_pkg::RST_CTRL_STATUS[1];
         wake_prescaler_ff <= hwc_pkg::RST_PRESCALER;
         timer_ctrl_ff <= hwc_pkg::RST_TIMER_CTRL[3:0];
         options_ff <= hwc_pkg::RST_OPTIONS[2:0];
      end else begin
         auto_wake_enable_ff <= nxt_auto_wake;
         wake_osc_measure_enable_ff <= nxt_measure;
         wake_prescaler_ff <= nxt_prescaler;
         timer_ctrl_ff <= nxt_timer_ctrl;
         options_ff <= nxt_options;
      end
   end

   // Flag: set beats the read clear; writes never touch it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wake_elapsed_flag_ff <= hwc_pkg::RST_CTRL_STATUS[2];
      end else if (timer_done && state_ff == hwc_pkg::ST_AUTO_WAKE) begin
         wake_elapsed_flag_ff <= 1'b1;
      end else if (rd_ctrl) begin
         wake_elapsed_flag_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------------
   wire in_auto = (nxt_state == hwc_pkg::ST_AUTO_WAKE);
   wire in_act = (nxt_state == hwc_pkg::ST_ACTIVE_HALT);
   wire in_halt = (nxt_state == hwc_pkg::ST_HALT);
   wire in_run = (nxt_state == hwc_pkg::ST_RUN);
   wire to_run = in_run && (state_ff != hwc_pkg::ST_RUN);

   // Clock gating and CPU handshakes follow the next state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cpu_stall_ff <= 1'b0;
         clear_mask_ff <= 1'b0;
         fetch_rv_ff <= 1'b0;
         service_ff <= 1'b0;
         wdg_rst_ff <= 1'b0;
         osc_ff <= 1'b1;
         periph_ff <= 1'b1;
         timer_ff <= 1'b1;
         cpuclk_ff <= 1'b1;
         rc_en_ff <= 1'b0;
         route_ff <= 1'b0;
      end else begin
         cpu_stall_ff <= !in_run;
         clear_mask_ff <= halt_fetch && !wdg_trip;
         fetch_rv_ff <= to_run && nxt_exit_by_reset;
         service_ff <= to_run && !nxt_exit_by_reset;
         wdg_rst_ff <= halt_fetch && wdg_trip;
         osc_ff <= !(in_auto || in_halt);
         periph_ff <= in_run;
         timer_ff <= in_run || in_act;
         // CPU clock held during multiplier wait
         cpuclk_ff <= in_run || in_act;
         rc_en_ff <= in_auto || (wake_osc_measure_enable_ff && in_run);
         route_ff <= wake_osc_measure_enable_ff && in_run;
      end
   end

   assign hrdata = hrdata_ff;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign cpu_stall = cpu_stall_ff;
   assign clear_int_mask = clear_mask_ff;
   assign fetch_reset_vector = fetch_rv_ff;
   assign service_irq = service_ff;
   assign wake_irq = wake_elapsed_flag_ff;
   assign watchdog_reset = wdg_rst_ff;
   assign main_osc_enable = osc_ff;
   assign periph_clk_enable = periph_ff;
   assign timer_clk_enable = timer_ff;
   assign cpu_clk_out_enable = cpuclk_ff;
   assign wake_rc_enable = rc_en_ff;
   assign capture_route_rc = route_ff;

endmodule : hwc_halt_wakeup_control

/* rtl/hwc_pkg.sv */
package hwc_pkg;

   // ------------------------------------------------------------------
   // Register map (byte addresses on the bus)
   // ------------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL_STATUS = 12'h000;
   localparam logic [11:0] ADDR_PRESCALER = 12'h004;
   localparam logic [11:0] ADDR_TIMER_CTRL = 12'h008;
   localparam logic [11:0] ADDR_OPTIONS = 12'h00C;
   localparam logic [11:0] ADDR_STATE = 12'h010;

   // ------------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------------
   localparam int BIT_AUTO_WAKE_ENABLE = 0;
   localparam int BIT_MEASURE_ENABLE = 1;
   localparam int BIT_ELAPSED_FLAG = 2;
   localparam int BIT_TB_IRQ_ENABLE = 0;
   localparam int BIT_OVF_IRQ_ENABLE = 1;
   localparam int BIT_CLK_SEL_LOW = 2;
   localparam int BIT_CLK_SEL_HIGH = 3;
   localparam int BIT_WDG_HALT_OPT = 0;
   localparam int BIT_LONG_STARTUP = 1;
   localparam int BIT_MULT_ENABLE = 2;
   localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
   localparam logic [7:0] RST_PRESCALER = 8'hFF;
   localparam logic [7:0] RST_TIMER_CTRL = 8'h00;
   localparam logic [7:0] RST_OPTIONS = 8'h00;

   // ------------------------------------------------------------------
   // Opcodes and counts
   // ------------------------------------------------------------------
   localparam logic [7:0] OPCODE_HALT = 8'h8E;
   localparam int FIXED_DIV = 64;
   localparam logic [12:0] STARTUP_SHORT = 13'h0100;
   localparam logic [12:0] STARTUP_LONG = 13'h1000;
   localparam logic [12:0] MULT_STARTUP = 13'h0040;

   // Power states
   typedef enum logic [2:0] {
      ST_RUN, ST_HALT, ST_ACTIVE_HALT, ST_AUTO_WAKE, ST_STARTUP, ST_MULT
   } hwc_state_type;

endpackage : hwc_pkg

/* rtl/hwc_wake_timer.sv */
// Wake-up delay: fixed divide then programmable prescaler, on an RC
// tick enable. Running only while enabled keeps the count fresh.
module hwc_wake_timer (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Control
   input wire logic run,
   input wire logic rc_tick,
   input wire logic [7:0] prescale,
   // Result
   output logic done
);

   logic [5:0] div_ff;
   logic [7:0] pre_ff;
   logic done_ff;
   wire div_wrap = (div_ff == 6'(hwc_pkg::FIXED_DIV - 1));
   // Forbidden zero prescale treated as one
   wire [7:0] pre_top = (prescale == 8'h00) ? 8'h01 : prescale;
   wire pre_wrap = (pre_ff == pre_top - 8'h01);

   // Divider chain
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_ff <= 6'h00;
         pre_ff <= 8'h00;
         done_ff <= 1'b0;
      end else if (!run) begin
         div_ff <= 6'h00;
         pre_ff <= 8'h00;
         done_ff <= 1'b0;
      end else if (rc_tick) begin
         div_ff <= div_wrap ? 6'h00 : div_ff + 6'h01;
         if (div_wrap) begin
            pre_ff <= pre_wrap ? 8'h00 : pre_ff + 8'h01;
         end
         done_ff <= div_wrap && pre_wrap;
      end else begin
         done_ff <= 1'b0;
      end
   end

   assign done = done_ff;

endmodule : hwc_wake_timer

/* tb/hwc_cpu_model.sv */
module hwc_cpu_model (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bench control
   input wire logic issue,
   input wire logic [7:0] issue_code,
   // Device side
   input wire logic cpu_stall,
   output logic opcode_fetch,
   output logic [7:0] opcode
);
   timeunit 1ns;
   timeprecision 1ns;
   // Fetch only while running; idle bus shows a changing pattern
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         opcode_fetch <= 1'b0;
         opcode <= 8'h00;
      end else if (issue && !cpu_stall) begin
         opcode_fetch <= 1'b1;
         opcode <= issue_code;
      end else begin
         opcode_fetch <= 1'b0;
         opcode <= ~opcode;
      end
   end
endmodule : hwc_cpu_model

/* tb/hwc_props.sv */
module hwc_props (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bus
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Core side
   input wire logic opcode_fetch,
   input wire logic [7:0] opcode,
   input wire logic wake_reset_req,
   input wire logic watchdog_active,
   input wire logic cpu_stall,
   input wire logic clear_int_mask,
   input wire logic fetch_reset_vector,
   input wire logic service_irq,
   input wire logic wake_irq,
   // Clock gating
   input wire logic main_osc_enable,
   input wire logic periph_clk_enable,
   input wire logic timer_clk_enable,
   input wire logic wake_rc_enable,
   input wire logic capture_route_rc
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // ------------------------------------------------------------
   // Helper: cycles since a reset request met a halted core
   // ------------------------------------------------------------
   // Counter instead of a long delay range; zero means idle
   logic [12:0] rst_wait_ff;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rst_wait_ff <= 13'h0000;
      end else if (fetch_reset_vector) begin
         rst_wait_ff <= 13'h0000;
      end else if (rst_wait_ff != 13'h0000) begin
         rst_wait_ff <= rst_wait_ff + 13'h0001;
      end else if ($rose(wake_reset_req) && cpu_stall) begin
         rst_wait_ff <= 13'h0001;
      end
   end

   // ------------------------------------------------------------
   // Steps named for use by the checks below
   // ------------------------------------------------------------
   sequence rd_ctrl_s;
      hsel && hready && htrans[1] && !hwrite
         && haddr == hwc_pkg::ADDR_CTRL_STATUS;
   endsequence
   // Watchdog and reset requests kept out: they pick other paths
   sequence halt_take_s;
      !cpu_stall && opcode_fetch && opcode == hwc_pkg::OPCODE_HALT
         && !watchdog_active && !wake_reset_req;
   endsequence

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   bus_answer_a: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   halt_entry_a: assert property (
      halt_take_s |=> cpu_stall && clear_int_mask)
      else $error("halt opcode did not stop the core");
   other_code_a: assert property (
      !cpu_stall && opcode_fetch && opcode != hwc_pkg::OPCODE_HALT
         && !wake_reset_req |=> !cpu_stall)
      else $error("ordinary opcode stopped the core");
   mask_pulse_a: assert property (clear_int_mask |=> !clear_int_mask)
      else $error("mask clear pulse too long");
   flag_read_a: assert property (
      rd_ctrl_s ##0 wake_irq |=> hrdata[2] ##1 !wake_irq)
      else $error("status read did not report then clear flag");
   reserved_zero_a: assert property (
      rd_ctrl_s |=> hrdata[31:3] == 29'h0)
      else $error("reserved status bits not zero");
   stall_exit_a: assert property (
      $fell(cpu_stall) |-> ##[0:1] (service_irq || fetch_reset_vector))
      else $error("return to run without vector");
   osc_off_a: assert property (
      cpu_stall && !main_osc_enable |-> !periph_clk_enable
         && !timer_clk_enable)
      else $error("clocks running with oscillator off");
   reset_exit_a: assert property (
      rst_wait_ff <= 13'h10CC)
      else $error("reset exit vector missing after startup");
   reset_early_a: assert property (
      fetch_reset_vector && rst_wait_ff != 13'h0000
         |-> rst_wait_ff >= 13'h0100)
      else $error("reset exit vector before startup ended");
   wake_flag_a: assert property ($rose(wake_irq) |-> cpu_stall)
      else $error("wake flag set while running");
   measure_rc_a: assert property (
      capture_route_rc |-> wake_rc_enable)
      else $error("capture routed with RC oscillator off");
endmodule : hwc_props

bind hwc_halt_wakeup_control hwc_props i_props (.hclk, .hresetn, .hsel,
   .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
   .opcode_fetch, .opcode, .wake_reset_req, .watchdog_active, .cpu_stall,
   .clear_int_mask, .fetch_reset_vector, .service_irq, .wake_irq,
   .main_osc_enable, .periph_clk_enable, .timer_clk_enable,
   .wake_rc_enable, .capture_route_rc);

/* tb/tb_halt_wakeup_control.sv */
module tb_halt_wakeup_control;
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0, hrdata, rd;
   logic [7:0] opcode, code = 8'h00;
   logic hreadyout, hresp, opcode_fetch, issue = 1'b0, wake_rc_clk_pin = 1'b0;
   logic wake_irq_pending = 1'b0, realtime_base_interrupt = 1'b0;
   logic wake_reset_req = 1'b0, watchdog_active = 1'b0;
   logic cpu_stall, clear_int_mask, fetch_reset_vector, service_irq;
   logic wake_irq, watchdog_reset, main_osc_enable, periph_clk_enable;
   logic timer_clk_enable, cpu_clk_out_enable, wake_rc_enable;
   logic capture_route_rc;
   int n_errors = 0, samples_checked = 0, n, wdg_seen;

   // 50 MHz bus clock; RC stand-in is slow, one period per seven bus clocks, edges on bus edges
   always #10 hclk = ~hclk;
   always #70 wake_rc_clk_pin = ~wake_rc_clk_pin;
   always @(posedge hclk) if (watchdog_reset === 1'b1) wdg_seen++;

   hwc_halt_wakeup_control i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .opcode_fetch, .opcode, .wake_irq_pending,
      .realtime_base_interrupt, .wake_reset_req, .watchdog_active,
      .cpu_stall, .clear_int_mask, .fetch_reset_vector, .service_irq,
      .wake_irq, .watchdog_reset, .main_osc_enable, .periph_clk_enable,
      .timer_clk_enable, .cpu_clk_out_enable, .wake_rc_clk_pin,
      .wake_rc_enable, .capture_route_rc);
   hwc_cpu_model i_cpu (.hclk, .hresetn, .issue, .issue_code(code),
      .cpu_stall, .opcode_fetch, .opcode);

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Single word transfer; read data taken at the data-phase edge
   task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task halt(input logic [7:0] c);
      issue <= 1'b1;
      code <= c;
      @(posedge hclk);
      issue <= 1'b0;
      repeat (3) @(posedge hclk);
   endtask : halt

   function automatic logic hit(input int sel);
      return sel == 0 ? service_irq : sel == 1 ? fetch_reset_vector : wake_irq;
   endfunction : hit

   // Counts cycles until the chosen output shows, bounded by lim
   task wait_out(input int sel, input int lim);
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hit(sel) !== 1'b1 && n < lim);
   endtask : wait_out

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_regs();
      bus(1'b0, hwc_pkg::ADDR_CTRL_STATUS, 32'h0);
      chk("status reset", 32'h0, rd);
      bus(1'b0, hwc_pkg::ADDR_PRESCALER, 32'h0);
      chk("prescaler reset", 32'hFF, rd);
      bus(1'b1, hwc_pkg::ADDR_CTRL_STATUS, 32'hFF);
      bus(1'b0, hwc_pkg::ADDR_CTRL_STATUS, 32'h0);
      chk("status write", 32'h03, rd);
      @(negedge hclk);
      chk("rc routed", 32'h1, capture_route_rc & wake_rc_enable);
      @(posedge hclk);
      bus(1'b1, hwc_pkg::ADDR_CTRL_STATUS, 32'h0);
      bus(1'b1, 12'h020, 32'hFF);
      bus(1'b0, 12'h020, 32'h0);
      chk("unmapped", 32'h0, rd);
   endtask : t_regs

   task t_select();
      logic [7:0] tc [4] = '{8'h01, 8'h06, 8'h0E, 8'h04};
      logic act [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, hwc_pkg::ADDR_TIMER_CTRL, {24'h0, tc[i]});
         halt(hwc_pkg::OPCODE_HALT);
         chk("stalled", 32'h1, cpu_stall);
         chk("osc kept", act[i], main_osc_enable);
         chk("periph clk", 32'h0, periph_clk_enable);
         chk("timer clk", act[i], timer_clk_enable);
         chk("cpu clk", act[i], cpu_clk_out_enable);
         if (i == 0) realtime_base_interrupt <= 1'b1;
         else wake_irq_pending <= 1'b1;
         wait_out(0, 400);
         realtime_base_interrupt <= 1'b0;
         wake_irq_pending <= 1'b0;
         chk("exit time", 32'h1, act[i] ? n < 8 : n >= 256 && n <= 264);
      end
      bus(1'b1, hwc_pkg::ADDR_TIMER_CTRL, 32'h0);
   endtask : t_select

   task t_auto();
      bus(1'b1, hwc_pkg::ADDR_PRESCALER, 32'h02);
      bus(1'b1, hwc_pkg::ADDR_TIMER_CTRL, 32'h01);
      bus(1'b1, hwc_pkg::ADDR_CTRL_STATUS, 32'h01);
      halt(hwc_pkg::OPCODE_HALT);
      chk("auto osc off", 32'h0, main_osc_enable);
      wait_out(2, 2000);
      chk("wake delay", 32'h1, n >= 880 && n <= 912);
      wait_out(0, 400);
      chk("wake startup", 32'h1, n >= 250 && n <= 264);
      bus(1'b0, hwc_pkg::ADDR_CTRL_STATUS, 32'h0);
      chk("flag read", 32'h05, rd);
      bus(1'b0, hwc_pkg::ADDR_CTRL_STATUS, 32'h0);
      chk("flag cleared", 32'h01, rd);
      bus(1'b1, hwc_pkg::ADDR_CTRL_STATUS, 32'h0);
   endtask : t_auto

   task t_reset_exit();
      bus(1'b1, hwc_pkg::ADDR_OPTIONS, 32'h06);
      halt(hwc_pkg::OPCODE_HALT);
      wake_reset_req <= 1'b1;
      wait_out(1, 4400);
      wake_reset_req <= 1'b0;
      chk("long startup", 32'h1, n >= 4160 && n <= 4168);
      bus(1'b1, hwc_pkg::ADDR_OPTIONS, 32'h0);
   endtask : t_reset_exit

   task t_watchdog();
      halt(8'h8F);
      chk("other opcode", 32'h0, cpu_stall);
      watchdog_active <= 1'b1;
      wdg_seen = 0;
      halt(hwc_pkg::OPCODE_HALT);
      chk("dog reset", 32'h1, wdg_seen != 0 && !cpu_stall);
      bus(1'b1, hwc_pkg::ADDR_TIMER_CTRL, 32'h01);
      wdg_seen = 0;
      halt(hwc_pkg::OPCODE_HALT);
      chk("dog quiet", 32'h1, wdg_seen == 0 && cpu_stall);
      wake_irq_pending <= 1'b1;
      wait_out(0, 20);
      wake_irq_pending <= 1'b0;
      watchdog_active <= 1'b0;
      chk("dog exit", 32'h1, n < 8);
      bus(1'b1, hwc_pkg::ADDR_TIMER_CTRL, 32'h0);
   endtask : t_watchdog

   task wrap_up();
      if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up

   // Main sequence; the active-halt reset exit runs with timer enables set
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_select();
      t_auto();
      bus(1'b1, hwc_pkg::ADDR_TIMER_CTRL, 32'h01);
      t_reset_exit();
      bus(1'b1, hwc_pkg::ADDR_TIMER_CTRL, 32'h0);
      t_watchdog();
      wrap_up();
   end

   // Hang guard, well past the longest expected run
   initial begin
      #400000;
      n_errors++;
      wrap_up();
   end
endmodule : tb_halt_wakeup_control
